// >>> tsp_pkg.sv
// How it works
// - Mode 10 with pin function 11 gives pulse
// - Run rising starts counter and leading edge
// - Trigger pin rising edge sets run bit
// - Run falling gives the trailing edge
// - Compare A match clears run bit
// - Compare A match raises interrupt in pulse mode
// - Counter cleared only on run rising edge
// - Compare P, clear select, swap ignored
// - Mode 01 selects capture operation
// - Run rising starts counter in capture
// - Capture edge copies counter into compare A
// - Counter free runs until run falls
// - Compare P match resets counter in capture
// - Compare P match raises interrupt in capture
// - Compare P zero gives full count range
// - Pin function picks edge; 11 blocks capture
// - Output level, invert, clear, swap ignored
// - Capture pin sampled even when driven
// - Run rising loads output initial level outside pulse and capture modes
// - Counter and compare A ten bits wide
package tsp_pkg;

	localparam int CNT_W = 10;
	localparam int COMPARE_P_VALUE_W = 3;
	localparam int ADR_W = 5;
	localparam int CTRL_W = 10;
	localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
	localparam logic [CNT_W-COMPARE_P_VALUE_W-1:0] P_LOW = 7'h00;

	// Register byte addresses
	localparam logic [ADR_W-1:0] ADR_CTRL = 5'h00;
	localparam logic [ADR_W-1:0] ADR_CMPA = 5'h04;
	localparam logic [ADR_W-1:0] ADR_CMPP = 5'h08;
	localparam logic [ADR_W-1:0] ADR_COUNT = 5'h0c;

	// Mode, pin function and edge encodings
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PULSE = 2'h2;
	localparam logic [1:0] PIN_PULSE = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	// Synchroniser lanes
	localparam int PIN_N = 3;
	localparam int PIN_TRIG = 0;
	localparam int PIN_CAP0 = 1;
	localparam int PIN_CAP1 = 2;

	// Control register layout, bit 9 downward
	typedef struct packed {
		logic capture_pin_select;
		logic duty_period_swap;
		logic clear_source_select;
		logic output_invert;
		logic output_initial_level;
		logic counter_run;
		logic [1:0] pin_function;
		logic [1:0] mode_select;
	} tsp_ctrl_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tsp_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} tsp_wb_rsp_t;

	typedef struct packed {
		tsp_ctrl_t ctrl;
		logic [CNT_W-1:0] compare_a_value;
		logic [COMPARE_P_VALUE_W-1:0] compare_p_value;
		logic [CNT_W-1:0] cnt;
		logic run_prev;
		logic pin_level;
		logic irq;
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] s3;
		tsp_wb_rsp_t rsp;
	} tsp_state_t;

	localparam tsp_state_t STATE_RESET = '0;

endpackage : tsp_pkg

// >>> tsp_timer.sv
`timescale 1ns/10ps
module tsp_timer (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire tsp_pkg::tsp_wb_req_t wb_req_i,
	output tsp_pkg::tsp_wb_rsp_t wb_rsp_o,
	input wire logic external_trigger_pin_i,
	input wire logic capture_input_0_i,
	input wire logic capture_input_1_i,
	output logic pulse_out_o,
	output logic timer_irq_o
);
	import tsp_pkg::*;

	tsp_state_t r;
	tsp_state_t next_r;

	logic [PIN_N-1:0] pin_rise;
	logic [PIN_N-1:0] pin_fall;
	logic pulse_mode;
	logic capture_mode;
	logic run_rise;
	logic a_match;
	logic p_match;
	logic cap_rise;
	logic cap_fall;
	logic cap_edge;
	logic cap_evt;
	logic trig_evt;
	logic a_stop;
	logic p_wrap;
	logic bus_wr;
	logic bus_rd;
	logic [31:0] wr_word;
	logic [31:0] rd_word;
	tsp_ctrl_t wr_ctrl;

	// Byte-lane merge of write data over an old word
	function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// Edges taken from the second and third sync stages only
	// capture pins sampled always
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_edge
			assign pin_rise[gi] = r.s2[gi] & ~r.s3[gi];
			assign pin_fall[gi] = ~r.s2[gi] & r.s3[gi];
		end
	endgenerate

	// Mode decode
	// pulse mode select
	assign pulse_mode = (r.ctrl.mode_select == MODE_PULSE) && (r.ctrl.pin_function == PIN_PULSE);
	assign capture_mode = r.ctrl.mode_select == MODE_CAPTURE;
	assign run_rise = r.ctrl.counter_run & ~r.run_prev;

	// Comparators; compare P only matters in capture mode
	// ten bit compare
	assign a_match = r.cnt == r.compare_a_value;
	assign p_match = (r.compare_p_value == '0) ? (r.cnt == CNT_MAX) : (r.cnt == {r.compare_p_value, P_LOW});

	// Capture pin choice and active edge
	// capture pin select
	assign cap_rise = r.ctrl.capture_pin_select ? pin_rise[PIN_CAP1] : pin_rise[PIN_CAP0];
	assign cap_fall = r.ctrl.capture_pin_select ? pin_fall[PIN_CAP1] : pin_fall[PIN_CAP0];

	always_comb begin
		case (r.ctrl.pin_function)
			EDGE_RISE: cap_edge = cap_rise;
			EDGE_FALL: cap_edge = cap_fall;
			EDGE_BOTH: cap_edge = cap_rise | cap_fall;
			default: cap_edge = 1'b0;
		endcase
	end

	// Events seen in the current cycle
	assign cap_evt = capture_mode & r.ctrl.counter_run & cap_edge;
	assign trig_evt = pulse_mode & pin_rise[PIN_TRIG];
	assign a_stop = pulse_mode & r.ctrl.counter_run & ~run_rise & a_match;
	assign p_wrap = capture_mode & r.ctrl.counter_run & ~run_rise & p_match;

	// Bus strobes; one access per request, answered next cycle
	assign bus_wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~r.rsp.ack;
	assign bus_rd = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~r.rsp.ack;

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (wb_req_i.adr)
			ADR_CTRL: rd_word = {{(32-CTRL_W){1'b0}}, r.ctrl};
			ADR_CMPA: rd_word = {{(32-CNT_W){1'b0}}, r.compare_a_value};
			ADR_CMPP: rd_word = {{(32-COMPARE_P_VALUE_W){1'b0}}, r.compare_p_value};
			ADR_COUNT: rd_word = {{(32-CNT_W){1'b0}}, r.cnt};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Next state: bus first, then hardware events which win
	always_comb begin
		next_r = r;
		wr_word = 32'h0000_0000;
		wr_ctrl = r.ctrl;
		next_r.rsp.ack = wb_req_i.cyc & wb_req_i.stb & ~r.rsp.ack;
		next_r.rsp.dat = bus_rd ? rd_word : 32'h0000_0000;
		next_r.run_prev = r.ctrl.counter_run;
		next_r.irq = 1'b0;
		next_r.s1 = {capture_input_1_i, capture_input_0_i, external_trigger_pin_i};
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;

		// Register writes
		if (bus_wr) begin
			case (wb_req_i.adr)
				ADR_CTRL: begin
					wr_word = lane_merge({{(32-CTRL_W){1'b0}}, r.ctrl}, wb_req_i.dat, wb_req_i.sel);
					wr_ctrl = tsp_ctrl_t'(wr_word[CTRL_W-1:0]);
					if (pulse_mode && wr_ctrl.mode_select == MODE_PULSE) begin
						wr_ctrl.pin_function = PIN_PULSE;
					end
					next_r.ctrl = wr_ctrl;
				end
				ADR_CMPA: begin
					wr_word = lane_merge({{(32-CNT_W){1'b0}}, r.compare_a_value}, wb_req_i.dat, wb_req_i.sel);
					next_r.compare_a_value = wr_word[CNT_W-1:0];
				end
				ADR_CMPP: begin
					wr_word = lane_merge({{(32-COMPARE_P_VALUE_W){1'b0}}, r.compare_p_value}, wb_req_i.dat, wb_req_i.sel);
					next_r.compare_p_value = wr_word[COMPARE_P_VALUE_W-1:0];
				end
				default: begin
					next_r.ctrl = r.ctrl;
				end
			endcase
		end

		// Counter
		if (run_rise) begin
			next_r.cnt = '0;
		end else if (r.ctrl.counter_run && capture_mode) begin
			next_r.cnt = p_wrap ? '0 : r.cnt + 10'h001;
		end else if (r.ctrl.counter_run && pulse_mode) begin
			next_r.cnt = r.cnt + 10'h001;
		end

		// Output pin level
		if (pulse_mode) begin
			next_r.pin_level = r.ctrl.counter_run ^ r.ctrl.output_invert;
		end else if (run_rise && !capture_mode) begin
			next_r.pin_level = r.ctrl.output_initial_level;
		end

		if (a_stop) begin
			next_r.ctrl.counter_run = 1'b0;
			next_r.irq = 1'b1;
		end

		if (p_wrap) begin
			next_r.irq = 1'b1;
		end

		if (cap_evt) begin
			next_r.compare_a_value = r.cnt;
			next_r.irq = 1'b1;
		end

		if (trig_evt) begin
			next_r.ctrl.counter_run = 1'b1;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= STATE_RESET;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	// Outputs straight from state
	assign wb_rsp_o = r.rsp;
	assign pulse_out_o = r.pin_level;
	assign timer_irq_o = r.irq;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	chk_pin_lock: assert property (
		ce_i && pulse_mode |=> (r.ctrl.mode_select != MODE_PULSE) || (r.ctrl.pin_function == PIN_PULSE))
		else $error("pin function changed in pulse mode");

	chk_pulse_start: assert property (
		ce_i && pulse_mode && run_rise && !trig_evt
		|=> (r.cnt == '0) && (pulse_out_o == ~r.ctrl.output_invert))
		else $error("pulse start did not clear counter or raise pin");

	chk_trig_run: assert property (
		ce_i && trig_evt |=> r.ctrl.counter_run)
		else $error("trigger edge did not set run");

	chk_pulse_trail: assert property (
		ce_i && pulse_mode && !r.ctrl.counter_run && $stable(r.ctrl)
		|=> pulse_out_o == r.ctrl.output_invert)
		else $error("pin active while run low");

	chk_a_stop: assert property (
		ce_i && a_stop && !trig_evt |=> !r.ctrl.counter_run ##1 (ce_i -> pulse_out_o == r.ctrl.output_invert))
		else $error("compare A did not end pulse");

	chk_a_irq: assert property (
		ce_i && a_stop |=> timer_irq_o)
		else $error("no interrupt on compare A");

	chk_cap_copy: assert property (
		ce_i && cap_evt |=> (r.compare_a_value == $past(r.cnt)) && timer_irq_o)
		else $error("capture did not copy counter");

	chk_cap_count: assert property (
		ce_i && capture_mode && r.ctrl.counter_run && !run_rise && !p_match
		|=> r.cnt == $past(r.cnt) + 10'h001)
		else $error("counter not free running");

	chk_p_wrap: assert property (
		ce_i && p_wrap |=> (r.cnt == '0) && timer_irq_o)
		else $error("compare P did not wrap counter");

	chk_edge_none: assert property (
		ce_i && capture_mode && (r.ctrl.pin_function == PIN_PULSE) && !bus_wr
		|=> $stable(r.compare_a_value))
		else $error("capture with edges disabled");

	chk_init_level: assert property (
		ce_i && run_rise && !pulse_mode && !capture_mode
		|=> pulse_out_o == $past(r.ctrl.output_initial_level))
		else $error("initial level not loaded");

	// Bus answers next cycle and drops after one
	chk_wb_ack: assert property (
		ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack ##1 (ce_i -> !wb_rsp_o.ack))
		else $error("bus ack timing wrong");

	cov_pulse_done: cover property (pulse_mode && run_rise ##[1:1000] a_stop);
	cov_capture: cover property (cap_evt);
	cov_wrap: cover property (p_wrap ##[1:1000] cap_evt);

endmodule : tsp_timer

// >>> tsp_pin_src.sv
`timescale 1ns/10ps
module tsp_pin_src (
	input wire logic clk_i,
	input wire logic [2:0] lvl_i,
	input wire logic slow_i,
	output logic [2:0] pin_o
);
	logic [2:0] d1 = '0;
	logic [2:0] d2 = '0;
	logic [2:0] d3 = '0;
	// Levels reach the pins one cycle late, or four cycles late when slow
	always @(posedge clk_i) begin
		d1 <= lvl_i;
		d2 <= d1;
		d3 <= d2;
		pin_o <= slow_i ? d3 : lvl_i;
	end
	initial pin_o = '0;
endmodule : tsp_pin_src

// >>> tb.sv
`timescale 1ns/10ps
module tb;
	import tsp_pkg::*;
	logic ref_clk_i = 0;
	logic rst_i = 1;
	logic slow = 0;
	logic [2:0] lvl = '0;
	logic [2:0] pin;
	tsp_wb_req_t req = '0;
	tsp_wb_rsp_t rsp;
	logic pulse;
	logic irq;
	logic [31:0] rd;
	int num_errors = 0;
	int n_tests = 0;
	int irqs = 0;
	int highs = 0;
	initial forever #5 ref_clk_i = ~ref_clk_i;
	tsp_timer i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(req),
		.wb_rsp_o(rsp), .external_trigger_pin_i(pin[PIN_TRIG]),
		.capture_input_0_i(pin[PIN_CAP0]), .capture_input_1_i(pin[PIN_CAP1]),
		.pulse_out_o(pulse), .timer_irq_o(irq));
	tsp_pin_src i_src (.clk_i(ref_clk_i), .lvl_i(lvl), .slow_i(slow), .pin_o(pin));
	// Count interrupt pulses and output-high cycles
	always @(posedge ref_clk_i) begin
		irqs <= irqs + int'(irq === 1'b1);
		highs <= highs + int'(pulse === 1'b1);
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input string m, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : cmp
	task automatic rng(input string m, input logic [31:0] got, input int lo, input int hi);
		n_tests++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h", $time, m, got);
		end
	endtask : rng
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : wait_n
	// One classic bus cycle; data taken at the ack edge
	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		int t;
		t = 0;
		req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge ref_clk_i);
			t++;
		end while (rsp.ack !== 1'b1 && t < 50);
		rd = rsp.dat;
		if (t >= 50) cmp("no ack", 32'h0, 32'h1);
		req <= '0;
		@(posedge ref_clk_i);
	endtask : wb
	function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] pf,
		input logic run, input logic [3:0] misc, input logic csel);
		tsp_ctrl_t c;
		c = '{csel, misc[3], misc[2], misc[1], misc[0], run, pf, md};
		return {22'h0, c};
	endfunction : ctl
	task automatic wrap(input logic [2:0] p, input int cyc, input int e);
		int i0;
		wb(1, ADR_CMPP, {29'h0, p});
		i0 = irqs;
		wb(1, ADR_CTRL, ctl(MODE_CAPTURE, 2'h3, 1, 4'($urandom), 0));
		wait_n(cyc);
		cmp("wraps", irqs - i0, e);
		wb(1, ADR_CTRL, 0);
	endtask : wrap
	// Stall guard
	initial begin
		#400000;
		$display("CHECK FAILED %0t timeout", $time);
		num_errors++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		int n, i0, h0, ne, wr;
		logic [31:0] c1;
		logic s;
		void'($urandom(32'h25cf));
		wait_n(3);
		rst_i <= 0;
		wait_n(1);
		wb(0, ADR_COUNT, 0);
		cmp("count reset", rd, 0);
		n = 3 + $urandom % 30;
		wb(1, ADR_CMPP, $urandom % 8);
		wb(1, ADR_CMPA, n);
		i0 = irqs;
		h0 = highs;
		wb(1, ADR_CTRL, ctl(MODE_PULSE, PIN_PULSE, 1, {2'($urandom), 2'h0}, 0));
		wait_n(n + 10);
		cmp("sw width", highs - h0, n + 2);
		cmp("sw irq", irqs - i0, 1);
		wb(0, ADR_CTRL, 0);
		cmp("run cleared", rd[4], 0);
		wb(0, ADR_COUNT, 0);
		cmp("count holds", rd, n + 1);
		i0 = irqs;
		h0 = highs;
		slow <= 1;
		wb(1, ADR_CTRL, ctl(MODE_PULSE, PIN_PULSE, 0, 0, 0));
		lvl[PIN_TRIG] <= 1;
		wait_n(n + 20);
		lvl <= '0;
		cmp("trig width", highs - h0, n + 2);
		cmp("trig irq", irqs - i0, 1);
		wb(1, ADR_CMPA, 500);
		i0 = irqs;
		h0 = highs;
		wb(1, ADR_CTRL, ctl(MODE_PULSE, PIN_PULSE, 1, 0, 0));
		wait_n(20);
		wb(1, ADR_CTRL, ctl(MODE_PULSE, 2'h0, 0, 0, 0));
		wait_n(5);
		rng("clear width", highs - h0, 20, 30);
		cmp("clear irq", irqs - i0, 0);
		wb(0, ADR_CTRL, 0);
		cmp("pin fn kept", rd[3:0], {PIN_PULSE, MODE_PULSE});
		wb(0, ADR_COUNT, 0);
		c1 = rd;
		wait_n(10);
		wb(0, ADR_COUNT, 0);
		cmp("no reset", rd, c1);
		for (int code = 0; code < 4; code++) begin
			s = 1'($urandom);
			wr = $urandom % 2;
			ne = (wr == 1 || code == 3) ? 0 : (code == 2) ? 2 : 1;
			slow <= 1'($urandom);
			wb(1, ADR_CMPP, 0);
			wb(1, ADR_CMPA, 0);
			i0 = irqs;
			h0 = highs;
			wb(1, ADR_CTRL, ctl(MODE_CAPTURE, 2'(code), 1, 4'($urandom), s));
			wait_n(30);
			lvl[PIN_CAP0 + int'(s ^ 1'(wr))] <= 1;
			wait_n(30);
			lvl <= '0;
			wait_n(30);
			wb(0, ADR_CMPA, 0);
			cmp("captures", irqs - i0, ne);
			if (ne > 0) rng("cap value", rd, 30, 70);
			else cmp("no capture", rd, 0);
			cmp("pin idle", highs - h0, 0);
			wb(1, ADR_CTRL, 0);
		end
		wrap(3'h1, 300, 2);
		wrap(3'h0, 1100, 1);
		// Plain mode run start loads the initial level onto the pin
		wb(1, ADR_CTRL, ctl(2'h0, 2'h0, 1, 4'h1, 0));
		wait_n(10);
		cmp("init level", {31'h0, pulse}, 1);
		wb(1, ADR_CTRL, 0);
		tally_and_finish;
	end
endmodule : tb
